// File: logic/volatile_config_and_freeze_lock.sv
// Purpose: Volatile configuration register 1 with freeze lock, reached by serial commands
// Assumes: Nonvolatile bits and the QPI select come from logic on clk
// Notes:   Nonvolatile and OTP programming leave as one-cycle requests
`timescale 1ns/1ps
`include "cfg1_lock_regs.svh"
module volatile_config_and_freeze_lock (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        cs_n,
   input  wire logic        sck,
   input  wire logic        si,
   input  wire logic        wp_n,
   input  wire logic        data3_or_reset_n,
   input  wire logic [7:0]  interface_protect_config_nonvolatile,
   input  wire logic        qpi_mode,
   output logic             so_out,
   output logic             so_oe,
   output logic [7:0]       interface_protect_config_volatile,
   output logic             wp_internal_n,
   output logic             io2_is_data,
   output logic             io3_is_data,
   output logic             hw_reset_active,
   output logic             config_ready,
   output logic             nv_cfg_wr,
   output logic [7:0]       nv_cfg_wr_data,
   output logic [7:0]       nv_cfg_wr_mask,
   output logic             sr1_wr,
   output logic [7:0]       sr1_wr_data,
   output logic             sr1_bp_wr_en,
   output logic             otp_prog_req,
   output logic [23:0]      otp_prog_addr,
   output logic [7:0]       otp_prog_data,
   output logic             prog_error_set
);
   spi_byte_if link ();

   cfg1_pkg::cmd_state_e state_reg;
   cfg1_pkg::byte_t      cmd_reg;
   cfg1_pkg::addr_t      addr_reg;
   logic [1:0]           addr_cnt_reg;
   logic [1:0]           data_cnt_reg;
   cfg1_pkg::byte_t      data0_reg;
   cfg1_pkg::byte_t      data1_reg;
   cfg1_pkg::byte_t      tx_byte_reg;
   logic                 tx_en_reg;
   cfg1_pkg::byte_t      cfg_reg;
   logic                 load_pending_reg;
   logic                 wp_internal_n_reg;
   logic                 io2_is_data_reg;
   logic                 io3_is_data_reg;
   logic                 hw_reset_reg;
   logic                 ready_reg;
   logic                 nv_cfg_wr_reg;
   cfg1_pkg::byte_t      nv_cfg_wr_data_reg;
   cfg1_pkg::byte_t      nv_cfg_wr_mask_reg;
   logic                 sr1_wr_reg;
   cfg1_pkg::byte_t      sr1_wr_data_reg;
   logic                 sr1_bp_wr_en_reg;
   logic                 otp_prog_req_reg;
   cfg1_pkg::addr_t      otp_prog_addr_reg;
   cfg1_pkg::byte_t      otp_prog_data_reg;
   logic                 prog_error_set_reg;

   spi_shift_engine u_engine (
      .clk              (clk),
      .rstn             (rstn),
      .cs_n             (cs_n),
      .sck              (sck),
      .si               (si),
      .wp_n             (wp_n),
      .data3_or_reset_n (data3_or_reset_n),
      .so_out           (so_out),
      .so_oe            (so_oe),
      .link             (link.engine)
   );

   wire [7:0]  nv         = interface_protect_config_nonvolatile;
   wire        frozen     = cfg_reg[`CFG_FREEZE_BIT];
   wire        hw_reset_s = !link.cs_active && !link.io3_s;
   wire        reload_all = load_pending_reg || hw_reset_s;
   wire        byte_in    = link.byte_valid;
   wire [7:0]  cur_cmd    = (state_reg == cfg1_pkg::st_cmd) ? link.rx_byte : cmd_reg;
   wire [23:0] addr_next  = {addr_reg[15:0], link.rx_byte};
   wire        addr_last  = (state_reg == cfg1_pkg::st_addr) && (addr_cnt_reg == 2'h2);
   wire        commit     = link.frame_end && ready_reg && (state_reg == cfg1_pkg::st_data);

   // Frame-end decode, so a write commits only once the host deselects
   wire wrr1_go   = commit && (cmd_reg == `CMD_WRITE_REGISTERS) && (data_cnt_reg == 2'h1);
   wire wrr2_go   = commit && (cmd_reg == `CMD_WRITE_REGISTERS) && (data_cnt_reg == 2'h2);
   wire write_any_register_cmd_go   = commit && (cmd_reg == `CMD_WRITE_ANY_REGISTER) && (data_cnt_reg == 2'h1);
   wire write_any_register_cmd_v    = write_any_register_cmd_go && (addr_reg == `CFG_VOLATILE_ADDR);
   wire write_any_register_cmd_nv   = write_any_register_cmd_go && (addr_reg == `CFG_NONVOLATILE_ADDR);
   wire soft_go   = commit && (cmd_reg == `CMD_SOFT_RESET) && (data_cnt_reg == 2'h0);
   wire otp_hit   = commit && (cmd_reg == `CMD_OTP_PROGRAM) && (data_cnt_reg != 2'h0)
                    && (addr_reg <= `OTP_LAST_ADDR);
   wire cfg_wr    = wrr2_go || write_any_register_cmd_v;
   wire nv_wr     = wrr2_go || write_any_register_cmd_nv;
   wire [7:0] cfg_data    = wrr2_go ? data1_reg : data0_reg;
   wire       quad_wr_val = cfg_data[`CFG_QUAD_BIT] || qpi_mode;

   // Quad follows its nonvolatile default on any reset, freeze survives soft reset
   wire quad_next = (reload_all || soft_go) ? nv[`CFG_QUAD_BIT]
                  : cfg_wr ? quad_wr_val
                  : cfg_reg[`CFG_QUAD_BIT];
   wire freeze_next = reload_all ? nv[`CFG_FREEZE_BIT]
                    : cfg_wr ? (frozen || cfg_data[`CFG_FREEZE_BIT])
                    : frozen;
   wire [7:0] cfg_next = (`CFG_VOLATILE_RESET & `CFG_RESERVED_MASK)
                       | (nv & `CFG_SHADOW_MASK)
                       | {6'h00, quad_next, freeze_next};

   // Shadow bits of the nonvolatile write come from host data, masked off while frozen
   wire [7:0] nv_data = {2'h0, cfg_data[`CFG_ORIGIN_BIT], 1'b0, cfg_data[`CFG_SOURCE_BIT],
                         cfg_data[`CFG_PARM_BIT], quad_wr_val, 1'b0};
   wire [7:0] nv_mask = {2'h0, !frozen, 1'b0, !frozen, !frozen, 1'b1, 1'b0};

   wire [7:0] rd_addr_val = (addr_next == `CFG_VOLATILE_ADDR) ? cfg_reg
                          : (addr_next == `CFG_NONVOLATILE_ADDR) ? nv : 8'h00;
   wire [7:0] rd_keep_val = (cmd_reg == `CMD_READ_CONFIG) ? cfg_reg : tx_byte_reg;
   wire read_config_cmd_start = (state_reg == cfg1_pkg::st_cmd) && (cur_cmd == `CMD_READ_CONFIG);
   wire read_any_register_cmd_start = addr_last && (cmd_reg == `CMD_READ_ANY_REGISTER);

   assign link.tx_byte = tx_byte_reg;
   assign link.tx_en   = tx_en_reg;

   assign interface_protect_config_volatile = cfg_reg;
   assign wp_internal_n   = wp_internal_n_reg;
   assign io2_is_data     = io2_is_data_reg;
   assign io3_is_data     = io3_is_data_reg;
   assign hw_reset_active = hw_reset_reg;
   assign config_ready    = ready_reg;
   assign nv_cfg_wr       = nv_cfg_wr_reg;
   assign nv_cfg_wr_data  = nv_cfg_wr_data_reg;
   assign nv_cfg_wr_mask  = nv_cfg_wr_mask_reg;
   assign sr1_wr          = sr1_wr_reg;
   assign sr1_wr_data     = sr1_wr_data_reg;
   assign sr1_bp_wr_en    = sr1_bp_wr_en_reg;
   assign otp_prog_req    = otp_prog_req_reg;
   assign otp_prog_addr   = otp_prog_addr_reg;
   assign otp_prog_data   = otp_prog_data_reg;
   assign prog_error_set  = prog_error_set_reg;

   // Frames arriving before the reload finishes are skipped whole
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= cfg1_pkg::st_idle;
         cmd_reg   <= 8'h00;
      end else if (link.frame_start) begin
         state_reg <= cfg1_pkg::st_cmd;
      end else if (link.frame_end) begin
         state_reg <= cfg1_pkg::st_idle;
      end else if (byte_in) begin
         unique case (state_reg)
            cfg1_pkg::st_cmd: begin
               cmd_reg <= link.rx_byte;
               if (!ready_reg)
                  state_reg <= cfg1_pkg::st_skip;
               else if (read_config_cmd_start)
                  state_reg <= cfg1_pkg::st_read;
               else if (cur_cmd == `CMD_WRITE_REGISTERS || cur_cmd == `CMD_SOFT_RESET)
                  state_reg <= cfg1_pkg::st_data;
               else if (cur_cmd == `CMD_READ_ANY_REGISTER || cur_cmd == `CMD_OTP_PROGRAM
                        || cur_cmd == `CMD_WRITE_ANY_REGISTER)
                  state_reg <= cfg1_pkg::st_addr;
               else
                  state_reg <= cfg1_pkg::st_skip;
            end
            cfg1_pkg::st_addr: begin
               if (addr_last)
                  state_reg <= read_any_register_cmd_start ? cfg1_pkg::st_read : cfg1_pkg::st_data;
            end
            cfg1_pkg::st_idle, cfg1_pkg::st_data, cfg1_pkg::st_read, cfg1_pkg::st_skip: begin
               state_reg <= state_reg;
            end
            default: state_reg <= cfg1_pkg::st_skip;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr_reg     <= 24'h000000;
         addr_cnt_reg <= 2'h0;
         data_cnt_reg <= 2'h0;
         data0_reg    <= 8'h00;
         data1_reg    <= 8'h00;
      end else if (link.frame_start) begin
         addr_cnt_reg <= 2'h0;
         data_cnt_reg <= 2'h0;
      end else if (byte_in && state_reg == cfg1_pkg::st_addr) begin
         addr_reg     <= addr_next;
         addr_cnt_reg <= addr_cnt_reg + 2'h1;
      end else if (byte_in && state_reg == cfg1_pkg::st_data) begin
         if (data_cnt_reg == 2'h0)
            data0_reg <= link.rx_byte;
         if (data_cnt_reg == 2'h1)
            data1_reg <= link.rx_byte;
         if (data_cnt_reg != 2'h3)
            data_cnt_reg <= data_cnt_reg + 2'h1;
      end
   end

   // Read data repeats for as long as the host keeps clocking
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_byte_reg <= 8'h00;
         tx_en_reg   <= 1'b0;
      end else if (link.frame_start || link.frame_end) begin
         tx_en_reg <= 1'b0;
      end else if (byte_in && ready_reg) begin
         if (read_config_cmd_start || read_any_register_cmd_start)
            tx_en_reg <= 1'b1;
         if (read_config_cmd_start || state_reg == cfg1_pkg::st_read)
            tx_byte_reg <= read_config_cmd_start ? cfg_reg : rd_keep_val;
         else if (read_any_register_cmd_start)
            tx_byte_reg <= rd_addr_val;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_reg          <= `CFG_VOLATILE_RESET;
         load_pending_reg <= 1'b1;
         ready_reg        <= 1'b0;
         hw_reset_reg     <= 1'b0;
      end else begin
         cfg_reg          <= cfg_next;
         load_pending_reg <= 1'b0;
         ready_reg        <= !reload_all;
         hw_reset_reg     <= hw_reset_s;
      end
   end

   // Pin roles follow the quad bit; protect input is ignored in quad mode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp_internal_n_reg <= 1'b1;
         io2_is_data_reg   <= 1'b0;
         io3_is_data_reg   <= 1'b0;
      end else begin
         wp_internal_n_reg <= cfg_reg[`CFG_QUAD_BIT] || link.wp_n_s;
         io2_is_data_reg   <= cfg_reg[`CFG_QUAD_BIT];
         io3_is_data_reg   <= cfg_reg[`CFG_QUAD_BIT] && link.cs_active;
      end
   end

   // Locked bits drop silently, only a frozen OTP program reports an error
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nv_cfg_wr_reg      <= 1'b0;
         nv_cfg_wr_data_reg <= 8'h00;
         nv_cfg_wr_mask_reg <= 8'h00;
         sr1_wr_reg         <= 1'b0;
         sr1_wr_data_reg    <= 8'h00;
         sr1_bp_wr_en_reg   <= 1'b0;
         otp_prog_req_reg   <= 1'b0;
         otp_prog_addr_reg  <= 24'h000000;
         otp_prog_data_reg  <= 8'h00;
         prog_error_set_reg <= 1'b0;
      end else begin
         nv_cfg_wr_reg      <= nv_wr;
         nv_cfg_wr_data_reg <= nv_data;
         nv_cfg_wr_mask_reg <= nv_mask;
         sr1_wr_reg         <= wrr1_go || wrr2_go;
         sr1_wr_data_reg    <= data0_reg;
         sr1_bp_wr_en_reg   <= !frozen;
         otp_prog_req_reg   <= otp_hit && !frozen;
         otp_prog_addr_reg  <= addr_reg;
         otp_prog_data_reg  <= data0_reg;
         prog_error_set_reg <= otp_hit && frozen;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_shadow_track: assert property (
      rstn |=> ((cfg_reg & `CFG_SHADOW_MASK) == ($past(nv) & `CFG_SHADOW_MASK)))
      else $error("shadow bits differ from nonvolatile bits");
   a_power_load: assert property (
      (rstn && load_pending_reg) |=> (frozen == $past(nv[`CFG_FREEZE_BIT])) ##1 ready_reg)
      else $error("freeze not loaded from default at power up");
   a_freeze_sticky: assert property (
      (frozen && !reload_all) |=> frozen)
      else $error("freeze cleared without reset");
   a_soft_keeps_freeze: assert property (
      (soft_go && !reload_all) |=> (frozen == $past(frozen)))
      else $error("software reset changed freeze");
   a_otp_frozen_fail: assert property (
      (otp_hit && frozen) |=> (prog_error_set && !otp_prog_req) ##1 !prog_error_set)
      else $error("frozen otp program not refused");
   a_nv_otp_gate: assert property (
      (nv_wr && frozen) |=> nv_cfg_wr && ((nv_cfg_wr_mask & `CFG_SHADOW_MASK) == 8'h00))
      else $error("otp config bits writable while frozen");
   a_qpi_keeps_quad: assert property (
      (qpi_mode && cfg_reg[`CFG_QUAD_BIT] && !reload_all && !soft_go)
      |=> cfg_reg[`CFG_QUAD_BIT])
      else $error("quad cleared while qpi selected");
   a_wp_quad_high: assert property (
      cfg_reg[`CFG_QUAD_BIT] [*2] |-> wp_internal_n && io2_is_data)
      else $error("write protect active in quad mode");
   a_wrr_both_quad: assert property (
      (wrr2_go && !reload_all) |=> nv_cfg_wr && nv_cfg_wr_mask[`CFG_QUAD_BIT]
      && (cfg_reg[`CFG_QUAD_BIT] == nv_cfg_wr_data[`CFG_QUAD_BIT]))
      else $error("write registers did not update both quad bits");
   a_read_config_cmd_return: assert property (
      (byte_in && ready_reg && read_config_cmd_start && !link.frame_start && !link.frame_end)
      |=> tx_en_reg && (tx_byte_reg == $past(cfg_reg)))
      else $error("read config did not load register");
endmodule : volatile_config_and_freeze_lock

// File: logic/cfg1_lock_regs.svh
// Purpose: Command codes, addresses, bit positions and masks of the config register 1 block
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef CFG1_LOCK_REGS_SVH
`define CFG1_LOCK_REGS_SVH

`define CMD_WRITE_REGISTERS    8'h01
`define CMD_READ_CONFIG        8'h35
`define CMD_READ_ANY_REGISTER  8'h65
`define CMD_WRITE_ANY_REGISTER 8'h71
`define CMD_OTP_PROGRAM        8'h42
`define CMD_SOFT_RESET         8'hf0

`define CFG_VOLATILE_ADDR      24'h800002
`define CFG_NONVOLATILE_ADDR   24'h000002
`define OTP_LAST_ADDR          24'h0003ff

`define CFG_FREEZE_BIT         0
`define CFG_QUAD_BIT           1
`define CFG_PARM_BIT           2
`define CFG_SOURCE_BIT         3
`define CFG_ORIGIN_BIT         5

`define CFG_SHADOW_MASK        8'h2c
`define CFG_RESERVED_MASK      8'hd0
`define CFG_VOLATILE_RESET     8'h00

`endif

// File: logic/cfg1_pkg.sv
// Purpose: Types shared by the config register 1 design files
// Assumes: Nothing is imported; users write cfg1_pkg::name
// Notes:   Binary state codes written out
package cfg1_pkg;

   typedef logic [7:0]  byte_t;
   typedef logic [23:0] addr_t;

   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_cmd  = 3'b001,
      st_addr = 3'b010,
      st_data = 3'b011,
      st_read = 3'b100,
      st_skip = 3'b101
   } cmd_state_e;

endpackage : cfg1_pkg

// File: logic/spi_byte_if.sv
// Purpose: Byte level link between the serial engine and the command logic
// Assumes: One clock, all signals on clk
// Notes:   Pulses last one clk cycle
`timescale 1ns/1ps
interface spi_byte_if;
   logic            frame_start;
   logic            frame_end;
   logic            byte_valid;
   cfg1_pkg::byte_t rx_byte;
   cfg1_pkg::byte_t tx_byte;
   logic            tx_en;
   logic            cs_active;
   logic            wp_n_s;
   logic            io3_s;

   modport engine (
      output frame_start,
      output frame_end,
      output byte_valid,
      output rx_byte,
      output cs_active,
      output wp_n_s,
      output io3_s,
      input  tx_byte,
      input  tx_en
   );

   modport ctrl (
      input  frame_start,
      input  frame_end,
      input  byte_valid,
      input  rx_byte,
      input  cs_active,
      input  wp_n_s,
      input  io3_s,
      output tx_byte,
      output tx_en
   );
endinterface : spi_byte_if

// File: logic/spi_shift_engine.sv
// Purpose: Samples the serial pins on clk, frames bytes and shifts read data out
// Assumes: Serial clock mode 0, at least 4 clk cycles per serial clock half period
// Notes:   Pins pass two flip-flops before use
`timescale 1ns/1ps
module spi_shift_engine (
   input  wire logic   clk,
   input  wire logic   rstn,
   input  wire logic   cs_n,
   input  wire logic   sck,
   input  wire logic   si,
   input  wire logic   wp_n,
   input  wire logic   data3_or_reset_n,
   output logic        so_out,
   output logic        so_oe,
   spi_byte_if.engine  link
);
   logic [4:0]      meta_reg;
   logic [4:0]      sync_reg;
   logic            sck_last_reg;
   logic            cs_last_reg;
   logic [2:0]      bit_cnt_reg;
   cfg1_pkg::byte_t shift_reg;
   cfg1_pkg::byte_t tx_shift_reg;
   logic            frame_start_reg;
   logic            frame_end_reg;
   logic            byte_valid_reg;
   cfg1_pkg::byte_t rx_byte_reg;

   wire             cs_active = !sync_reg[0];
   wire             sck_rise  = sync_reg[1] && !sck_last_reg;
   wire             sck_fall  = !sync_reg[1] && sck_last_reg;
   wire [7:0]       rx_next   = {shift_reg[6:0], sync_reg[2]};
   wire             tx_load   = (bit_cnt_reg == 3'h0);

   assign link.frame_start = frame_start_reg;
   assign link.frame_end   = frame_end_reg;
   assign link.byte_valid  = byte_valid_reg;
   assign link.rx_byte     = rx_byte_reg;
   assign link.cs_active   = cs_active;
   assign link.wp_n_s      = sync_reg[3];
   assign link.io3_s       = sync_reg[4];

   // Second stage is the only reader of the first
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         // Sck stage resets to its idle low level, so no false edge follows reset
         meta_reg     <= 5'h1d;
         sync_reg     <= 5'h1d;
         sck_last_reg <= 1'b0;
         cs_last_reg  <= 1'b1;
      end else begin
         meta_reg     <= {data3_or_reset_n, wp_n, si, sck, cs_n};
         sync_reg     <= meta_reg;
         sck_last_reg <= sync_reg[1];
         cs_last_reg  <= sync_reg[0];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         frame_start_reg <= 1'b0;
         frame_end_reg   <= 1'b0;
      end else begin
         frame_start_reg <= cs_last_reg && !sync_reg[0];
         frame_end_reg   <= !cs_last_reg && sync_reg[0];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bit_cnt_reg    <= 3'h0;
         shift_reg      <= 8'h00;
         byte_valid_reg <= 1'b0;
         rx_byte_reg    <= 8'h00;
      end else if (!cs_active) begin
         bit_cnt_reg    <= 3'h0;
         byte_valid_reg <= 1'b0;
      end else begin
         byte_valid_reg <= sck_rise && (bit_cnt_reg == 3'h7);
         if (sck_rise) begin
            shift_reg   <= rx_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            rx_byte_reg <= rx_next;
         end
      end
   end

   // Read byte is fetched on the falling edge that follows a byte boundary
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         so_out       <= 1'b0;
         so_oe        <= 1'b0;
         tx_shift_reg <= 8'h00;
      end else begin
         so_oe <= cs_active && link.tx_en;
         if (cs_active && sck_fall) begin
            so_out       <= tx_load ? link.tx_byte[7] : tx_shift_reg[7];
            tx_shift_reg <= tx_load ? {link.tx_byte[6:0], 1'b0} : {tx_shift_reg[6:0], 1'b0};
         end
      end
   end
endmodule : spi_shift_engine

// File: testbench/spi_host.sv
// Purpose: Host side serial command driver
// Assumes: Mode 0, sck period of 8 clk cycles
// Notes:   Idle data line shows the inverse of its last bit
`timescale 1ns/1ps
module spi_host (
   input  wire logic clk,
   output logic      cs_n,
   output logic      sck,
   output logic      si,
   input  wire logic so_out
);
   logic [7:0] rx;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   // Whole bytes only, MSB first
   task automatic frame(input logic [39:0] q, input int n);
      @(posedge clk) cs_n <= 1'b0;
      for (int i = 0; i < 8 * n; i++) begin
         @(posedge clk) si <= q[39 - i];
         repeat (3) @(posedge clk);
         sck <= 1'b1;
         rx <= {rx[6:0], so_out};
         repeat (4) @(posedge clk);
         sck <= 1'b0;
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      // Stale level would hide a missed sample
      si <= ~si;
      repeat (12) @(posedge clk);
   endtask : frame
endmodule : spi_host

// File: testbench/volatile_config_and_freeze_lock_tb.sv
// Purpose: Self-checking bench of the volatile config register with freeze lock
// Assumes: One command per frame
// Notes:   Expected values follow from the nonvolatile input and written bytes
`timescale 1ns/1ps
`include "cfg1_lock_regs.svh"
module volatile_config_and_freeze_lock_tb;
   logic       clk;
   logic       rstn;
   logic       wp_n;
   logic       io3_n;
   logic       qpi;
   logic [7:0] nv;
   logic [7:0] cfg;
   logic       wpi_n;
   logic       io2_d;
   logic       bp_en;
   logic       rdy;
   logic       so_out;
   logic       nvw;
   logic       otpq;
   logic       perr;
   logic       hwr;
   logic [7:0] nvm;
   logic [7:0] nvm_cap;
   int         n_nvw = 0;
   int         n_otp = 0;
   int         n_perr = 0;
   wire        cs_n;
   wire        sck;
   wire        si;
   int         n_errors = 0;
   int         num_checks = 0;
   spi_host HOST (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out));
   volatile_config_and_freeze_lock DUT (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sck(sck),
      .si(si), .wp_n(wp_n), .data3_or_reset_n(io3_n), .qpi_mode(qpi),
      .interface_protect_config_nonvolatile(nv), .so_out(so_out), .so_oe(),
      .interface_protect_config_volatile(cfg), .wp_internal_n(wpi_n),
      .io2_is_data(io2_d), .io3_is_data(), .hw_reset_active(hwr), .config_ready(rdy),
      .nv_cfg_wr(nvw), .nv_cfg_wr_data(), .nv_cfg_wr_mask(nvm), .sr1_wr(), .sr1_wr_data(),
      .sr1_bp_wr_en(bp_en), .otp_prog_req(otpq), .otp_prog_addr(), .otp_prog_data(),
      .prog_error_set(perr));
   // Pulses last one cycle, so they are counted here and judged later
   always @(posedge clk) begin
      if (nvw === 1'b1) begin
         n_nvw++;
         nvm_cap = nvm;
      end
      if (otpq === 1'b1)
         n_otp++;
      if (perr === 1'b1)
         n_perr++;
   end
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_rdy;
      for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(posedge clk);
      repeat (3) @(posedge clk);
   endtask : wait_rdy
   task automatic wr_any(input logic [7:0] d, input logic [7:0] exp);
      HOST.frame({`CMD_WRITE_ANY_REGISTER, `CFG_VOLATILE_ADDR, d}, 5);
      HOST.frame({`CMD_READ_CONFIG, 32'h0}, 2);
      chk(HOST.rx, exp);
      chk(cfg, exp);
   endtask : wr_any
   task automatic sc_lock;
      wr_any(8'hd1, 8'h2d);
      chk({7'h0, bp_en}, 8'h00);
      chk({6'h0, wpi_n, io2_d}, 8'h00);
      HOST.frame({`CMD_SOFT_RESET, 32'h0}, 1);
      chk(cfg, 8'h2f);
      wr_any(8'h00, 8'h2d);
      wr_any(8'h02, 8'h2f);
      chk({6'h0, wpi_n, io2_d}, 8'h03);
      HOST.frame({`CMD_WRITE_ANY_REGISTER, `CFG_NONVOLATILE_ADDR, 8'h2c}, 5);
      chk(nvm_cap, 8'h02);
      chk(cfg, 8'h2f);
      HOST.frame({`CMD_OTP_PROGRAM, 24'h000010, 8'h55}, 5);
      chk({n_otp[3:0], n_perr[3:0]}, 8'h01);
   endtask : sc_lock
   task automatic sc_qpi;
      qpi <= 1'b1;
      wr_any(8'h00, 8'h2f);
      qpi <= 1'b0;
   endtask : sc_qpi
   task automatic sc_reload;
      nv <= 8'h02;
      repeat (3) @(posedge clk);
      chk(cfg, 8'h03);
      io3_n <= 1'b0;
      repeat (8) @(posedge clk);
      chk({7'h0, hwr}, 8'h01);
      io3_n <= 1'b1;
      wait_rdy();
      chk(cfg, 8'h02);
      HOST.frame({`CMD_READ_ANY_REGISTER, `CFG_VOLATILE_ADDR, 8'h0}, 5);
      chk(HOST.rx, 8'h02);
      HOST.frame({`CMD_OTP_PROGRAM, 24'h000010, 8'h55}, 5);
      chk({n_otp[3:0], n_perr[3:0]}, 8'h11);
      HOST.frame({`CMD_WRITE_REGISTERS, 16'h0, 16'h0}, 3);
      chk(cfg, 8'h00);
      chk(n_nvw[7:0], 8'h02);
      chk(nvm_cap, 8'h2e);
   endtask : sc_reload
   task automatic end_of_test;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      #2000000;
      n_errors++;
      end_of_test();
   end
   initial begin
      rstn = 1'b0;
      wp_n = 1'b0;
      io3_n = 1'b1;
      qpi = 1'b0;
      nv = 8'h2e;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      wait_rdy();
      chk(cfg, 8'h2e);
      sc_lock();
      sc_qpi();
      sc_reload();
      end_of_test();
   end
endmodule : volatile_config_and_freeze_lock_tb
